/* File: dv/eipf_irq_flags_asserts.sv */
// eipf_irq_flags_asserts: checker of the irq flag block
// assumes it is bound to eipf_irq_flags and sees only its ports
module eipf_irq_flags_asserts
    import eipf_pkg::*;
#(
    parameter bit HAS_HOST_PORT = 1'b1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire eipf_events_s events,
    input wire eipf_ccp_mode_e ccp_mode,
    input wire eipf_bus_s bus,
    input wire logic [7:0] rdata,
    input wire logic irq_high,
    input wire logic irq_low,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wr_seen;
    // ---
    // checks
    // ---
    // any write since reset; enables all start off
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wr_seen <= 1'b0;
        else if (bus.wr)
            wr_seen <= 1'b1;
    end
    // read of the peripheral flags
    sequence s_rdp;
        bus.rd && bus.addr == 4'h1;
    endsequence
    property p_gap;
        $past(bus.rd) && $past(bus.addr) == 4'h0 |-> !rdata[5] && !rdata[2];
    endproperty
    a_gap: assert property (p_gap) else $error("gap bit set");
    property p_host;
        events.host_cycle ##1 s_rdp |=> rdata[7] == HAS_HOST_PORT;
    endproperty
    a_host: assert property (p_host) else $error("host flag");
    property p_conv;
        events.conv_done ##1 s_rdp |=> rdata[6];
    endproperty
    a_conv: assert property (p_conv) else $error("conv flag");
    property p_ssp;
        events.ssp_done ##1 s_rdp |=> rdata[3];
    endproperty
    a_ssp: assert property (p_ssp) else $error("ssp flag");
    property p_ccp;
        (events.capture && ccp_mode == EIPF_CCP_CAPTURE
            || events.compare && ccp_mode == EIPF_CCP_COMPARE) ##1 s_rdp |=> rdata[2];
    endproperty
    a_ccp: assert property (p_ccp) else $error("ccp flag");
    property p_tmrb;
        events.tmrb_match ##1 s_rdp |=> rdata[1];
    endproperty
    a_tmrb: assert property (p_tmrb) else $error("timer b flag");
    property p_tmra;
        events.tmra_ovf ##1 s_rdp |=> rdata[0];
    endproperty
    a_tmra: assert property (p_tmra) else $error("timer a flag");
    property p_quiet;
        !wr_seen |-> !irq_high && !irq_low && !irq;
    endproperty
    a_quiet: assert property (p_quiet) else $error("request unenabled");
    c_high: cover property (irq_high);
    c_low: cover property (irq_low);
    c_irq: cover property ($rose(irq));
endmodule // eipf_irq_flags_asserts

bind eipf_irq_flags eipf_irq_flags_asserts #(.HAS_HOST_PORT(HAS_HOST_PORT))
    u_eipf_irq_flags_asserts (.clk(clk), .rst(rst), .ext_irq_a_pin(ext_irq_a_pin),
    .ext_irq_b_pin(ext_irq_b_pin), .events(events), .ccp_mode(ccp_mode), .bus(bus),
    .rdata(rdata), .irq_high(irq_high), .irq_low(irq_low), .irq(irq));

/* File: dv/eipf_irq_flags_tb_top.sv */
// eipf_irq_flags_tb_top: self-checking bench of the irq flag block
// assumes the model and the bound checker are compiled with it
module eipf_irq_flags_tb_top
    import eipf_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    eipf_bus_s bus = '0;
    eipf_ccp_mode_e ccp_mode = EIPF_CCP_CAPTURE;
    eipf_events_s events;
    logic a_pin;
    logic b_pin;
    logic irq_high;
    logic irq_low;
    logic irq;
    logic [7:0] rdata;
    logic [7:0] d;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    // ---
    // harness
    // ---
    always #20 clk = ~clk;
    eipf_periph_model u_eipf_periph_model (.clk(clk), .events(events),
        .ext_irq_a_pin(a_pin), .ext_irq_b_pin(b_pin));
    eipf_irq_flags u_eipf_irq_flags (.clk(clk), .rst(rst), .ext_irq_a_pin(a_pin),
        .ext_irq_b_pin(b_pin), .events(events), .ccp_mode(ccp_mode), .bus(bus),
        .rdata(rdata), .irq_high(irq_high), .irq_low(irq_low), .irq(irq));
    // cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        reg_rd(a, v);
        chk("reg", e, v);
    endtask
    // requests settle, then {irq, high, low}
    task automatic req_chk(input logic [7:0] e);
        repeat (3) @(posedge clk);
        #1;
        chk("req", e, {5'h0, irq, irq_high, irq_low});
    endtask
    // event pulse with a flag read right behind it
    task automatic pulse_rd(input int idx, output logic [7:0] v);
        fork
            u_eipf_periph_model.pulse(idx);
            begin
                @(posedge clk);
                reg_rd(4'h1, v);
            end
        join
    endtask
    // ---
    // scenarios
    // ---
    task automatic t_reset();
        logic [7:0] e[7] = '{8'hc0, 8'h10, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++)
            rd_chk(i == 6 ? 4'hf : 4'(i), e[i]);
    endtask
    task automatic t_ctrl();
        reg_wr(4'h0, 8'hff);
        rd_chk(4'h0, 8'hdb);
        reg_wr(4'h0, 8'h00);
        rd_chk(4'h0, 8'h00);
        reg_wr(4'hf, 8'hff);
        rd_chk(4'hf, 8'h00);
    endtask
    task automatic t_prio();
        logic [7:0] c[6] = '{8'h09, 8'h49, 8'h41, 8'h12, 8'h92, 8'h82};
        logic [7:0] e[6] = '{8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00};
        for (int i = 0; i < 6; i++)
        begin
            reg_wr(4'h0, c[i]);
            req_chk(e[i]);
        end
        reg_wr(4'h0, 8'h00);
    endtask
    task automatic t_pins();
        u_eipf_periph_model.pin(0);
        rd_chk(4'h0, 8'h01);
        u_eipf_periph_model.pin(1);
        rd_chk(4'h0, 8'h03);
        reg_wr(4'h0, 8'h00);
        rd_chk(4'h0, 8'h00);
    endtask
    task automatic t_periph();
        int idx[7] = '{8, 7, 4, 3, 2, 1, 0};
        int b[7] = '{7, 6, 3, 2, 2, 1, 0};
        for (int i = 0; i < 7; i++)
        begin
            reg_wr(4'h1, 8'h00);
            if (idx[i] == 2)
                ccp_mode <= EIPF_CCP_COMPARE;
            else
                ccp_mode <= EIPF_CCP_CAPTURE;
            pulse_rd(idx[i], d);
            chk("flag", 8'h10 | (8'h01 << b[i]), d);
        end
        reg_wr(4'h1, 8'h00);
        ccp_mode <= EIPF_CCP_PWM;
        pulse_rd(3, d);
        chk("pwm", 8'h10, d);
        pulse_rd(2, d);
        chk("pwm", 8'h10, d);
    endtask
    task automatic t_levels();
        u_eipf_periph_model.levels(1'b1, 1'b0);
        reg_wr(4'h1, 8'h00);
        rd_chk(4'h1, 8'h20);
        u_eipf_periph_model.levels(1'b0, 1'b1);
        rd_chk(4'h1, 8'h10);
        reg_wr(4'h1, 8'hff);
        rd_chk(4'h1, 8'hdf);
        fork
            u_eipf_periph_model.pulse(0);
            reg_wr(4'h1, 8'h00);
        join
        rd_chk(4'h1, 8'h11);
    endtask
    task automatic t_status();
        reg_wr(4'h1, 8'h00);
        reg_wr(4'h2, 8'h03);
        reg_wr(4'h4, 8'h00);
        reg_wr(4'h5, 8'h01);
        u_eipf_periph_model.pulse(0);
        req_chk(8'h01);
        reg_wr(4'h3, 8'h02);
        req_chk(8'h05);
        reg_wr(4'h4, 8'h01);
        req_chk(8'h06);
        rd_chk(4'h2, 8'h03);
        reg_wr(4'h1, 8'h00);
        repeat (2) @(posedge clk);
        reg_wr(4'h2, 8'h03);
        req_chk(8'h00);
    endtask
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ctrl();
        t_prio();
        t_pins();
        t_periph();
        t_levels();
        t_status();
        report_and_stop();
    end
endmodule // eipf_irq_flags_tb_top

/* File: dv/eipf_periph_model.sv */
// eipf_periph_model: peripherals and pins beside the flag block
// assumes its tasks are called right after a rising clk edge
module eipf_periph_model
    import eipf_pkg::*;
(
    input wire logic clk,
    output eipf_events_s events,
    output logic ext_irq_a_pin,
    output logic ext_irq_b_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pins;
    // ---
    // drivers
    // ---
    assign ext_irq_a_pin = pins[0];
    assign ext_irq_b_pin = pins[1];
    // idle, transmit buffer empty
    initial
    begin
        events = '0;
        events.tx_empty = 1'b1;
        pins = 2'h0;
    end
    // one-cycle pulse on struct bit idx
    task automatic pulse(input int idx);
        @(posedge clk);
        events[idx] <= 1'b1;
        @(posedge clk);
        events[idx] <= 1'b0;
    endtask
    // buffer levels
    task automatic levels(input logic rx, input logic tx);
        @(posedge clk);
        events.rx_full <= rx;
        events.tx_empty <= tx;
    endtask
    // pin held three cycles high, three low
    task automatic pin(input int b);
        @(posedge clk);
        pins[b] <= 1'b1;
        repeat (3) @(posedge clk);
        pins[b] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule // eipf_periph_model

/* File: verilog/eipf_edge_sync.sv */
// eipf_edge_sync: two-stage synchroniser and rising edge detector for a pin
// assumes the pin is asynchronous to clk
module eipf_edge_sync
    import eipf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic rise
);
    logic meta;
    logic sync;
    logic last;

    // only sync reads meta
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            last <= sync;
        end
    end

    assign rise = sync & ~last;
endmodule // eipf_edge_sync

/* File: verilog/eipf_irq_flags.sv */
// eipf_irq_flags: flag, enable and priority logic for two external
// interrupt pins and the first peripheral flag register
// assumes peripheral event inputs are one-cycle pulses on clk,
// rx_full and tx_empty are levels; pins are asynchronous
// assumes a register port whose strobes last one cycle and never
// come together; reset is asynchronous and active high
//
// Operation
// - flags set regardless of any enable
// - control bit 7 is pin B priority
// - control bit 6 is pin A priority
// - control bit 4 enables pin B
// - control bit 3 enables pin A
// - bit 1 set on pin B event
// - bit 0 set on pin A event
// - bits 5, 2 read zero, ignore writes
// - host port flag set per host cycle
// - converter flag set when conversion completes
// - receive flag mirrors buffer full, read-only
// - transmit flag high while buffer empty
// - sync serial flag set on completion
// - capcomp flag on capture in capture mode or compare in compare mode only
// - timer B flag on period match
// - timer A flag on count overflow
module eipf_irq_flags
    import eipf_pkg::*;
#(
    parameter bit HAS_HOST_PORT = 1'b1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire eipf_events_s events,
    input wire eipf_ccp_mode_e ccp_mode,
    input wire eipf_bus_s bus,
    output logic [7:0] rdata,
    output logic irq_high,
    output logic irq_low,
    output logic irq
);
    `include "eipf_params.svh"

    // -------------------------------------------------------------
    // constants
    // -------------------------------------------------------------
    // host flag position kept only where the host port exists
    localparam logic [7:0] HOST_KEEP = {HAS_HOST_PORT, {`EIPF_B_HOST{1'b1}}};

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [7:0] ext_cfg;
    logic ext_flag_a;
    logic ext_flag_b;
    logic [7:0] ext_ctrl;
    logic [7:0] periph_flags;
    logic [7:0] periph_prio;
    logic [7:0] periph_en;
    logic [`EIPF_ST_W-1:0] irq_status;
    logic [`EIPF_ST_W-1:0] irq_mask;
    logic rise_a;
    logic rise_b;
    logic [7:0] ext_rd;
    logic [7:0] periph_rd;
    logic [7:0] set_bits;
    logic next_high;
    logic next_low;

    function automatic logic wr_to(input eipf_bus_s b, input logic [`EIPF_ADDR_W-1:0] off);
        wr_to = b.wr && (b.addr == off);
    endfunction

    function automatic logic rd_of(input eipf_bus_s b, input logic [`EIPF_ADDR_W-1:0] off);
        rd_of = b.rd && (b.addr == off);
    endfunction

    // -------------------------------------------------------------
    // pin edge detection
    // -------------------------------------------------------------
    eipf_edge_sync u_sync_a (
        .clk(clk),
        .rst(rst),
        .pin(ext_irq_a_pin),
        .rise(rise_a)
    );

    eipf_edge_sync u_sync_b (
        .clk(clk),
        .rst(rst),
        .pin(ext_irq_b_pin),
        .rise(rise_b)
    );

    // -------------------------------------------------------------
    // external control register
    // -------------------------------------------------------------
    // priority and enable bits: plain read/write, gaps held at zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_cfg <= `EIPF_EXT_CTRL_RST & `EIPF_EXT_CFG_MASK;
        end
        else if (wr_to(bus, `EIPF_OFF_EXT_CTRL))
        begin
            ext_cfg <= bus.wdata & `EIPF_EXT_CFG_MASK;
        end
    end

    // pin A flag: an edge beats a write in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_flag_a <= `EIPF_FLAG_RST;
        end
        else if (rise_a)
        begin
            ext_flag_a <= 1'b1;
        end
        else if (wr_to(bus, `EIPF_OFF_EXT_CTRL))
        begin
            ext_flag_a <= bus.wdata[`EIPF_B_FLAG_A];
        end
    end

    // pin B flag: an edge beats a write in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_flag_b <= `EIPF_FLAG_RST;
        end
        else if (rise_b)
        begin
            ext_flag_b <= 1'b1;
        end
        else if (wr_to(bus, `EIPF_OFF_EXT_CTRL))
        begin
            ext_flag_b <= bus.wdata[`EIPF_B_FLAG_B];
        end
    end

    // register image used by reads and by request logic
    always_comb
    begin
        ext_ctrl = ext_cfg;
        ext_ctrl[`EIPF_B_FLAG_A] = ext_flag_a;
        ext_ctrl[`EIPF_B_FLAG_B] = ext_flag_b;
    end

    // -------------------------------------------------------------
    // peripheral flag register
    // -------------------------------------------------------------
    // set terms of the sticky flags, independent of enables
    always_comb
    begin
        set_bits = 8'h00;
        set_bits[`EIPF_B_HOST] = events.host_cycle & HAS_HOST_PORT;
        set_bits[`EIPF_B_CONV] = events.conv_done;
        set_bits[`EIPF_B_SSP] = events.ssp_done;
        set_bits[`EIPF_B_CCP] = (events.capture && ccp_mode == EIPF_CCP_CAPTURE)
            || (events.compare && ccp_mode == EIPF_CCP_COMPARE);
        set_bits[`EIPF_B_TMRB] = events.tmrb_match;
        set_bits[`EIPF_B_TMRA] = events.tmra_ovf;
    end

    // software writes writable bits; a set in the same cycle wins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            periph_flags <= `EIPF_PERIPH_RST;
        end
        else
        begin
            if (wr_to(bus, `EIPF_OFF_PERIPH))
            begin
                periph_flags <= ((bus.wdata & `EIPF_PERIPH_WMASK) | set_bits)
                    & HOST_KEEP;
            end
            else
            begin
                periph_flags <= (periph_flags | set_bits) & HOST_KEEP;
            end
        end
    end

    // serial flags are live levels, read-only
    always_comb
    begin
        periph_rd = periph_flags;
        periph_rd[`EIPF_B_RX] = events.rx_full;
        periph_rd[`EIPF_B_TX] = events.tx_empty;
        ext_rd = ext_ctrl & `EIPF_EXT_CTRL_WMASK;
    end

    // -------------------------------------------------------------
    // peripheral priority and enable registers
    // -------------------------------------------------------------
    // priority per peripheral flag: 1 routes it to the high level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            periph_prio <= `EIPF_PERIPH_PRIO_RST;
        end
        else if (wr_to(bus, `EIPF_OFF_PERIPH_PRIO))
        begin
            periph_prio <= bus.wdata;
        end
    end

    // enable per peripheral flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            periph_en <= `EIPF_PERIPH_EN_RST;
        end
        else if (wr_to(bus, `EIPF_OFF_PERIPH_EN))
        begin
            periph_en <= bus.wdata;
        end
    end

    // -------------------------------------------------------------
    // request generation
    // -------------------------------------------------------------
    // flag and enable together, routed by priority bit
    always_comb
    begin
        next_high = (ext_ctrl[`EIPF_B_FLAG_A] & ext_ctrl[`EIPF_B_EN_A]
                & ext_ctrl[`EIPF_B_PRIO_A])
            | (ext_ctrl[`EIPF_B_FLAG_B] & ext_ctrl[`EIPF_B_EN_B]
                & ext_ctrl[`EIPF_B_PRIO_B])
            | (|(periph_rd & periph_en & periph_prio));
        next_low = (ext_ctrl[`EIPF_B_FLAG_A] & ext_ctrl[`EIPF_B_EN_A]
                & ~ext_ctrl[`EIPF_B_PRIO_A])
            | (ext_ctrl[`EIPF_B_FLAG_B] & ext_ctrl[`EIPF_B_EN_B]
                & ~ext_ctrl[`EIPF_B_PRIO_B])
            | (|(periph_rd & periph_en & ~periph_prio));
    end

    // both request levels registered so the outputs leave flops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_high <= 1'b0;
            irq_low <= 1'b0;
        end
        else
        begin
            irq_high <= next_high;
            irq_low <= next_low;
        end
    end

    // -------------------------------------------------------------
    // sticky request status, mask and summary interrupt
    // -------------------------------------------------------------
    // active request levels set status every cycle they are high; write one clears; set wins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_status <= `EIPF_ST_RST;
        end
        else
        begin
            if (wr_to(bus, `EIPF_OFF_IRQ_STATUS))
            begin
                irq_status <= (irq_status & ~bus.wdata[`EIPF_ST_W-1:0])
                    | {next_low, next_high};
            end
            else
            begin
                irq_status <= irq_status | {next_low, next_high};
            end
        end
    end

    // mask of the status bits, same layout
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask <= `EIPF_ST_RST;
        end
        else if (wr_to(bus, `EIPF_OFF_IRQ_MASK))
        begin
            irq_mask <= bus.wdata[`EIPF_ST_W-1:0];
        end
    end

    // level interrupt while an unmasked status bit is set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // -------------------------------------------------------------
    // read port: data in the cycle after the strobe, zero otherwise
    // -------------------------------------------------------------
    // one select per register; unmapped offsets and idle cycles read zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= `EIPF_RDATA_IDLE;
        end
        else if (rd_of(bus, `EIPF_OFF_EXT_CTRL))
        begin
            rdata <= ext_rd;
        end
        else if (rd_of(bus, `EIPF_OFF_PERIPH))
        begin
            rdata <= periph_rd;
        end
        else if (rd_of(bus, `EIPF_OFF_IRQ_STATUS))
        begin
            rdata <= {6'h00, irq_status};
        end
        else if (rd_of(bus, `EIPF_OFF_IRQ_MASK))
        begin
            rdata <= {6'h00, irq_mask};
        end
        else if (rd_of(bus, `EIPF_OFF_PERIPH_PRIO))
        begin
            rdata <= periph_prio;
        end
        else if (rd_of(bus, `EIPF_OFF_PERIPH_EN))
        begin
            rdata <= periph_en;
        end
        else
        begin
            rdata <= `EIPF_RDATA_IDLE;
        end
    end
endmodule // eipf_irq_flags

/* File: verilog/eipf_params.svh */
// eipf_params.svh: offsets, bit positions and reset values of the irq flag block
// assumes inclusion by the package and the modules of this block only
`ifndef EIPF_PARAMS_SVH
`define EIPF_PARAMS_SVH

`define EIPF_ADDR_W 4
`define EIPF_OFF_EXT_CTRL 4'h0
`define EIPF_OFF_PERIPH 4'h1
`define EIPF_OFF_IRQ_STATUS 4'h2
`define EIPF_OFF_IRQ_MASK 4'h3
`define EIPF_OFF_PERIPH_PRIO 4'h4
`define EIPF_OFF_PERIPH_EN 4'h5

// external control register fields
`define EIPF_B_PRIO_B 7
`define EIPF_B_PRIO_A 6
`define EIPF_B_EN_B 4
`define EIPF_B_EN_A 3
`define EIPF_B_FLAG_B 1
`define EIPF_B_FLAG_A 0
`define EIPF_EXT_CTRL_RST 8'hc0
`define EIPF_EXT_CTRL_WMASK 8'hdb
`define EIPF_EXT_CFG_MASK 8'hd8
`define EIPF_FLAG_RST 1'b0

// peripheral flag register fields
`define EIPF_B_HOST 7
`define EIPF_B_CONV 6
`define EIPF_B_RX 5
`define EIPF_B_TX 4
`define EIPF_B_SSP 3
`define EIPF_B_CCP 2
`define EIPF_B_TMRB 1
`define EIPF_B_TMRA 0
`define EIPF_PERIPH_RST 8'h00
`define EIPF_PERIPH_WMASK 8'hcf
`define EIPF_PERIPH_PRIO_RST 8'hff
`define EIPF_PERIPH_EN_RST 8'h00
`define EIPF_RDATA_IDLE 8'h00

// interrupt status bits, one per request level (high, low)
`define EIPF_ST_HI 0
`define EIPF_ST_LO 1
`define EIPF_ST_W 2
`define EIPF_ST_RST 2'h0

`endif

/* File: verilog/eipf_pkg.sv */
// eipf_pkg: types shared by the irq flag block
// assumes eipf_params.svh is on the include path
package eipf_pkg;
`include "eipf_params.svh"

    typedef enum logic [2:0] {
        EIPF_CCP_CAPTURE = 3'h1,
        EIPF_CCP_COMPARE = 3'h2,
        EIPF_CCP_PWM = 3'h4
    } eipf_ccp_mode_e;

    // peripheral event pulses and the two buffer levels; capture and compare share one flag
    typedef struct packed {
        logic host_cycle;
        logic conv_done;
        logic rx_full;
        logic tx_empty;
        logic ssp_done;
        logic capture;
        logic compare;
        logic tmrb_match;
        logic tmra_ovf;
    } eipf_events_s;

    typedef struct packed {
        logic [`EIPF_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } eipf_bus_s;
endpackage
